// ### core/spi_flow_pkg.sv
// Shared constants and carrier types for the serial flow-control block.
// Assumes one 125 MHz peripheral clock drives every process.
package spi_flow_pkg;

  // Data path and FIFO shape
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 4'h8;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // Clock period in nanoseconds
  localparam int T_SYS_NS = 8;

  // Ready seen to select low: two peripheral clock periods
  localparam int SEL_DLY_NS = 2 * T_SYS_NS;
  localparam int SEL_DLY_CYC = (SEL_DLY_NS + T_SYS_NS - 1) / T_SYS_NS;
  localparam logic [1:0] SEL_DLY_LAST = 2'(SEL_DLY_CYC - 1);

  // Serial-clock period counts, held as half periods
  localparam int LEAD_SCLK = 3;
  localparam int TRAIL_SCLK = 2;
  localparam int GAP_BASE_SCLK = 1;
  localparam logic [4:0] LEAD_LAST = 5'(2 * LEAD_SCLK - 1);
  localparam logic [4:0] TRAIL_LAST = 5'(2 * TRAIL_SCLK - 1);
  localparam logic [4:0] GAP_BASE_LAST = 5'(2 * GAP_BASE_SCLK - 1);
  localparam logic [4:0] SHIFT_LAST = 5'(2 * DATA_W - 1);

  // Width of the programmed wait count
  localparam int WAIT_W = 15;

  // How a master transfer is allowed to start
  typedef enum logic [1:0] {
    RDY_IGNORE = 2'h0,  // Fixed rate from the sample period
    RDY_EDGE = 2'h1,    // Falling edge of ready
    RDY_LEVEL = 2'h2    // Ready held low
  } rdy_mode_t;

  // Static configuration carried as one bundle
  typedef struct packed {
    logic master;             // 1: master, 0: slave
    rdy_mode_t rdy_mode;      // Start pacing in master mode
    logic cpol;               // Serial clock idle level
    logic cpha;               // 0: sample leading, 1: sample trailing
    logic [3:0] div;          // Half sclk period = div+1 clocks
    logic [WAIT_W-1:0] wait_cnt;  // Extra gap between frames
    logic wait_32k;           // 1: gap in 32.768 kHz ticks
  } cfg_t;

endpackage

// ### core/spi_fifo_mem.sv
// Small storage array for one FIFO, read data from a register.
// Assumes the caller owns pointers and never writes and reads one slot
// expecting bypass; read data lag the address by one clock.
`timescale 1ns/1ps
module spi_fifo_mem (
  // Clock and enable
  input wire logic mclk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [spi_flow_pkg::PTR_W-1:0] waddr,
  input wire logic [spi_flow_pkg::DATA_W-1:0] wdata,
  // Read port
  input wire logic [spi_flow_pkg::PTR_W-1:0] raddr,
  output logic [spi_flow_pkg::DATA_W-1:0] rdata_q
);

  // Storage, no reset needed
  logic [spi_flow_pkg::DATA_W-1:0] mem [spi_flow_pkg::FIFO_DEPTH];

  // Write side
  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the output glitch free
  always_ff @(posedge mclk) begin
    if (ce) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// ### core/spi_flow_ctrl.sv
// Serial peripheral flow control: master pacing and slave framing.
// Assumes all pins are already synchronous to mclk and that the far
// side keeps its own timing rules.
//
// Behaviour
// - Master paces transfers by select and ready.
// - Sample period may fix rate, ignoring ready.
// - Slave select edges load/latch shifter, step FIFO.
// - Slave sampling and shifting follow configured phase.
// - Select low two clocks after ready seen.
// - Three sclk periods from select to clock.
// - Two sclk periods after last edge, then high.
// - Select high gap: one sclk plus wait.
// - Wait counts sclk periods or 32k ticks.
// - Master may start on ready falling edge.
// - Slave FIFO advances on select rising edge.
`timescale 1ns/1ps
module spi_flow_ctrl (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Configuration and slow tick
  input wire spi_flow_pkg::cfg_t cfg,
  input wire logic tick_32k,
  // Transmit stream in
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [spi_flow_pkg::DATA_W-1:0] tx_data,
  // Receive stream out
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [spi_flow_pkg::DATA_W-1:0] rx_data,
  // Serial clock pin
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  // Select pin, active low
  input wire logic select_n_i,
  output logic select_n_o,
  output logic select_n_oe,
  // Ready from external slave, active low
  input wire logic ready_n_i,
  // Data pins
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // Status
  output logic busy
);

  // Master sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SEL = 6'b000010,
    S_LEAD = 6'b000100,
    S_SHIFT = 6'b001000,
    S_TRAIL = 6'b010000,
    S_GAP = 6'b100000
  } state_t;

  // Which edge launches data; the other edge samples
  function automatic logic launch_on(input logic leading,
                                     input logic cpha);
    launch_on = cpha ? leading : !leading;
  endfunction

  state_t state_q;             // Master state
  logic [1:0] tmr_q;           // Clocks spent in S_SEL
  logic [3:0] div_q;           // Half-period divider
  logic [4:0] hcnt_q;          // Half periods in current phase
  logic base_done_q;           // Fixed part of gap done
  logic [spi_flow_pkg::WAIT_W:0] wcnt_q;  // Wait units counted
  logic sclk_q;                // Driven serial clock
  logic sel_q;                 // Driven select, low active
  logic pend_q;                // Ready falling edge caught
  logic rdy_prev_q;            // Ready one clock ago
  logic sel_prev_q;            // Select pin one clock ago
  logic sclk_prev_q;           // Clock pin one clock ago
  logic slv_loaded_q;          // Slave took a FIFO word
  logic [spi_flow_pkg::DATA_W-1:0] tsh_q;  // Outgoing shifter
  logic [spi_flow_pkg::DATA_W-1:0] rsh_q;  // Incoming shifter
  logic dout_q;                // Bit on the output pin

  // FIFO plumbing, index 0 transmit, 1 receive
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] head_ok;
  logic [spi_flow_pkg::DATA_W-1:0] wdat [2];
  logic [spi_flow_pkg::DATA_W-1:0] rdat [2];
  logic [spi_flow_pkg::CNT_W-1:0] cnt [2];

  // Event terms
  logic half_tick;
  logic go;
  logic start_ok;
  logic m_load;
  logic m_edge;
  logic m_push;
  logic s_fall;
  logic s_rise;
  logic s_edge;
  logic s_lead;
  logic ld;
  logic edge_ev;
  logic lead_ev;
  logic gap_unit;
  logic [spi_flow_pkg::WAIT_W:0] gap_need;
  logic rx_room;

  // Transmit and receive FIFOs share one shape
  generate
    for (genvar i = 0; i < 2; i++) begin : g_fifo
      logic [spi_flow_pkg::PTR_W-1:0] wp_q;
      logic [spi_flow_pkg::PTR_W-1:0] rp_q;
      logic [spi_flow_pkg::CNT_W-1:0] n_q;
      logic [1:0] chg_q;  // Read register still settling

      // Pointers and fill level
      always_ff @(posedge mclk) begin
        if (rst) begin
          wp_q <= '0;
          rp_q <= '0;
          n_q <= '0;
          chg_q <= 2'h0;
        end else if (ce) begin
          if (push[i]) begin
            wp_q <= wp_q + 1'b1;
          end
          if (pop[i]) begin
            rp_q <= rp_q + 1'b1;
          end
          n_q <= n_q + {3'h0, push[i]} - {3'h0, pop[i]};
          // Head word only moves on a pop or a push into an empty
          // store; later pushes must not hide a word already shown
          chg_q <= {chg_q[0], pop[i] | (push[i] && n_q == '0)};
        end
      end

      assign cnt[i] = n_q;
      assign head_ok[i] = (n_q != '0) && (chg_q == 2'h0);

      spi_fifo_mem u_mem (
        .mclk(mclk),
        .ce(ce),
        .we(push[i]),
        .waddr(wp_q),
        .wdata(wdat[i]),
        .raddr(rp_q),
        .rdata_q(rdat[i])
      );
    end
  endgenerate

  // User stream handshakes
  assign tx_ready = cnt[0] != spi_flow_pkg::FIFO_FULL_CNT;
  assign push[0] = tx_valid && tx_ready;
  assign wdat[0] = tx_data;
  assign rx_valid = head_ok[1];
  assign rx_data = rdat[1];
  assign pop[1] = rx_valid && rx_ready;
  assign rx_room = cnt[1] != spi_flow_pkg::FIFO_FULL_CNT;
  assign wdat[1] = rsh_q;

  // Start pacing: ready level, ready edge, or fixed rate
  always_comb begin
    case (cfg.rdy_mode)
      spi_flow_pkg::RDY_EDGE: go = pend_q;
      spi_flow_pkg::RDY_LEVEL: go = !ready_n_i;
      default: go = 1'b1;
    endcase
  end
  // Words must be waiting and there must be room for the reply
  assign start_ok = cfg.master && head_ok[0] && rx_room && go;

  // Half-period tick from the divider
  assign half_tick = (div_q == cfg.div);

  // Gap units: half serial periods, with the wait doubled, or slow ticks
  assign gap_unit = cfg.wait_32k ? tick_32k : half_tick;
  assign gap_need = cfg.wait_32k ? {1'b0, cfg.wait_cnt}
                                 : {cfg.wait_cnt, 1'b0};

  // Divider restarts in idle so every phase starts aligned
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= 4'h0;
    end else if (ce) begin
      if (state_q == S_IDLE || state_q == S_SEL || half_tick) begin
        div_q <= 4'h0;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // Catch ready falling edges; a new edge beats the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdy_prev_q <= 1'b1;
      pend_q <= 1'b0;
    end else if (ce) begin
      rdy_prev_q <= ready_n_i;
      if (rdy_prev_q && !ready_n_i) begin
        pend_q <= 1'b1;
      end else if (state_q == S_IDLE && start_ok) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Master sequencer: delay, lead, shift, trail, gap
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= S_IDLE;
      tmr_q <= 2'h0;
      hcnt_q <= 5'h0;
      base_done_q <= 1'b0;
      wcnt_q <= '0;
      sel_q <= 1'b1;
    end else if (ce) begin
      case (state_q)
        S_IDLE: begin
          tmr_q <= 2'h0;
          hcnt_q <= 5'h0;
          if (start_ok) begin
            state_q <= S_SEL;
          end
        end
        S_SEL: begin
          // Hold select high while the ready delay runs out
          if (tmr_q == spi_flow_pkg::SEL_DLY_LAST) begin
            state_q <= S_LEAD;
            sel_q <= 1'b0;
          end else begin
            tmr_q <= tmr_q + 2'h1;
          end
        end
        S_LEAD: begin
          if (half_tick) begin
            hcnt_q <= hcnt_q + 5'h1;
            if (hcnt_q == spi_flow_pkg::LEAD_LAST) begin
              state_q <= S_SHIFT;
              hcnt_q <= 5'h0;
            end
          end
        end
        S_SHIFT: begin
          if (half_tick) begin
            hcnt_q <= hcnt_q + 5'h1;
            if (hcnt_q == spi_flow_pkg::SHIFT_LAST) begin
              state_q <= S_TRAIL;
              hcnt_q <= 5'h0;
            end
          end
        end
        S_TRAIL: begin
          if (half_tick) begin
            hcnt_q <= hcnt_q + 5'h1;
            if (hcnt_q == spi_flow_pkg::TRAIL_LAST) begin
              state_q <= S_GAP;
              sel_q <= 1'b1;
              hcnt_q <= 5'h0;
              base_done_q <= 1'b0;
              wcnt_q <= '0;
            end
          end
        end
        S_GAP: begin
          // One serial period first, then the programmed wait
          if (!base_done_q) begin
            if (half_tick) begin
              hcnt_q <= hcnt_q + 5'h1;
              if (hcnt_q == spi_flow_pkg::GAP_BASE_LAST) begin
                base_done_q <= 1'b1;
              end
            end
          end else if (wcnt_q >= gap_need) begin
            state_q <= S_IDLE;
          end else if (gap_unit) begin
            wcnt_q <= wcnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          sel_q <= 1'b1;
        end
      endcase
    end
  end

  // Driven serial clock toggles only while shifting
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else if (ce) begin
      if (state_q == S_SHIFT && half_tick) begin
        sclk_q <= !sclk_q;
      end else if (state_q != S_SHIFT) begin
        sclk_q <= cfg.cpol;
      end
    end
  end

  // Slave pin history for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      sel_prev_q <= select_n_i;
      sclk_prev_q <= sclk_i;
    end
  end

  // Master events
  assign m_load = state_q == S_SEL && tmr_q == spi_flow_pkg::SEL_DLY_LAST;
  assign m_edge = state_q == S_SHIFT && half_tick;
  assign m_push = state_q == S_TRAIL && half_tick &&
                  hcnt_q == spi_flow_pkg::TRAIL_LAST;

  // Slave events; clock edges only count inside a select frame
  assign s_fall = !cfg.master && sel_prev_q && !select_n_i;
  assign s_rise = !cfg.master && !sel_prev_q && select_n_i;
  assign s_edge = !cfg.master && !select_n_i && (sclk_i != sclk_prev_q);
  assign s_lead = sclk_prev_q == cfg.cpol;

  // Merged shift events of both modes
  assign ld = cfg.master ? m_load : s_fall;
  assign edge_ev = cfg.master ? m_edge : s_edge;
  assign lead_ev = cfg.master ? !hcnt_q[0] : s_lead;

  // FIFO steps: master per frame, slave on select rising edge
  assign pop[0] = cfg.master ? m_load : (s_rise && slv_loaded_q);
  assign push[1] = cfg.master ? m_push : (s_rise && rx_room);

  // Slave remembers whether a real word was loaded
  always_ff @(posedge mclk) begin
    if (rst) begin
      slv_loaded_q <= 1'b0;
    end else if (ce) begin
      if (s_fall) begin
        slv_loaded_q <= head_ok[0];
      end else if (s_rise) begin
        slv_loaded_q <= 1'b0;
      end
    end
  end

  // Shift registers; an empty FIFO sends zeros in slave mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      tsh_q <= spi_flow_pkg::DATA_RESET;
      rsh_q <= spi_flow_pkg::DATA_RESET;
      dout_q <= 1'b0;
    end else if (ce) begin
      if (ld) begin
        // Phase 0 puts the first bit out before any clock edge
        if (!cfg.cpha) begin
          dout_q <= head_ok[0] ? rdat[0][spi_flow_pkg::DATA_W-1] : 1'b0;
          tsh_q <= head_ok[0] ? {rdat[0][spi_flow_pkg::DATA_W-2:0], 1'b0}
                              : spi_flow_pkg::DATA_RESET;
        end else begin
          tsh_q <= head_ok[0] ? rdat[0] : spi_flow_pkg::DATA_RESET;
        end
      end else if (edge_ev) begin
        if (launch_on(lead_ev, cfg.cpha)) begin
          dout_q <= tsh_q[spi_flow_pkg::DATA_W-1];
          tsh_q <= {tsh_q[spi_flow_pkg::DATA_W-2:0], 1'b0};
        end else begin
          rsh_q <= {rsh_q[spi_flow_pkg::DATA_W-2:0],
                    cfg.master ? miso_i : mosi_i};
        end
      end
    end
  end

  // Pin drive: master owns clock, select and mosi
  assign sclk_o = sclk_q;
  assign sclk_oe = cfg.master;
  assign select_n_o = sel_q;
  assign select_n_oe = cfg.master;
  assign mosi_o = dout_q;
  assign mosi_oe = cfg.master;
  // Slave drives miso only while selected by the far master
  assign miso_o = dout_q;
  assign miso_oe = !cfg.master && !select_n_i;
  assign busy = (state_q != S_IDLE) || !sel_prev_q;

endmodule

// ### verification/spi_flow_ctrl_props.sv
// Pin checker for the serial flow-control block.
// Assumes one clock and a synchronous reset; bound from the bench.
`timescale 1ns/1ps
module spi_flow_ctrl_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Inputs seen
  input wire spi_flow_pkg::cfg_t cfg,
  input wire logic tick_32k,
  input wire logic ready_n_i,
  input wire logic rx_ready,
  input wire logic select_n_i,
  // Outputs seen
  input wire logic rx_valid,
  input wire logic sclk_o,
  input wire logic select_n_o,
  input wire logic select_n_oe,
  input wire logic sclk_oe,
  input wire logic mosi_oe,
  input wire logic busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // High side starts full, so reset never looks like a short gap
  logic [15:0] lo_q;
  logic [15:0] ed_q;
  logic [15:0] hi_q;
  logic [15:0] tk_q;
  logic [4:0] tg_q;
  int half;
  assign half = int'(cfg.div) + 1;
  // Low time, time since sclk moved, high time, ticks, toggles
  always_ff @(posedge mclk) begin
    if (rst) begin
      lo_q <= 16'h0;
      ed_q <= 16'h0;
      hi_q <= 16'hffff;
      tk_q <= 16'hffff;
      tg_q <= 5'h0;
    end else begin
      lo_q <= select_n_o ? 16'h0 : lo_q + 16'h1;
      ed_q <= $changed(sclk_o) ? 16'h1 : ed_q + {15'h0, ~&ed_q};
      hi_q <= select_n_o ? hi_q + {15'h0, ~&hi_q} : 16'h0;
      tk_q <= select_n_o ? tk_q + {15'h0, tick_32k & ~&tk_q} : 16'h0;
      tg_q <= select_n_o ? 5'h0 : tg_q + {4'h0, $changed(sclk_o)};
    end
  end
  lead_gap_a: assert property (
    cfg.master && !select_n_o && $changed(sclk_o) |-> int'(lo_q) >= 6 * half)
    else $error("sclk too soon");
  trail_gap_a: assert property (
    cfg.master && $rose(select_n_o) |-> int'(ed_q) >= 4 * half)
    else $error("select rose too soon");
  frame_gap_a: assert property (
    cfg.master && !cfg.wait_32k && $fell(select_n_o)
    |-> int'(hi_q) >= 2 * half * (1 + int'(cfg.wait_cnt)))
    else $error("gap short");
  tick_gap_a: assert property (
    cfg.master && cfg.wait_32k && $fell(select_n_o)
    |-> tk_q >= 16'(cfg.wait_cnt) && int'(hi_q) >= 2 * half)
    else $error("tick gap short");
  ready_wait_a: assert property (
    cfg.master && !busy && select_n_o && $fell(ready_n_i) &&
    cfg.rdy_mode inside {spi_flow_pkg::RDY_EDGE, spi_flow_pkg::RDY_LEVEL}
    |-> select_n_o [*3])
    else $error("select fell too soon");
  bit_count_a: assert property (
    cfg.master && $rose(select_n_o) |-> tg_q == 5'h10)
    else $error("toggle count wrong");
  slave_oe_a: assert property (
    !cfg.master |-> !select_n_oe && !sclk_oe && !mosi_oe)
    else $error("slave drives pins");
  rx_push_a: assert property (
    (cfg.master ? $rose(select_n_o) : $rose(select_n_i)) && !rx_ready
    |-> ##[1:4] rx_valid)
    else $error("no word after select");
  cover property (cfg.master && $fell(select_n_o));
  cover property (cfg.wait_32k && $fell(select_n_o));
  cover property (!cfg.master && $rose(select_n_i));
endmodule

// ### verification/spi_slave_model.sv
// Far-side slave: answers master frames and paces them with ready.
// Assumes sclk and select move slowly against mclk.
`timescale 1ns/1ps
module spi_slave_model (
  // Clock and mode
  input wire logic mclk,
  input wire logic cpol,
  input wire logic cpha,
  // Master side pins
  input wire logic select_n,
  input wire logic sclk,
  input wire logic mosi,
  // Bench control
  input wire logic [7:0] reply,
  input wire logic req,
  // Answers
  output logic miso,
  output logic ready_n,
  output logic [7:0] got
);
  logic sclk_p = 1'b0;
  logic sel_p = 1'b1;
  logic tog = 1'b0;
  logic rdy_q = 1'b1;
  logic [8:0] sh = 9'h0;
  logic lead;
  logic trail;
  assign lead = sclk != sclk_p && sclk != cpol;
  assign trail = sclk != sclk_p && sclk == cpol;
  // Released line toggles so a stale bit never reads as good
  assign miso = select_n ? tog : sh[8];
  assign ready_n = rdy_q;
  // Edge watch, shifting and ready pacing
  always_ff @(posedge mclk) begin
    sclk_p <= sclk;
    sel_p <= select_n;
    tog <= ~tog;
    // Ready only falls while select is high
    if (select_n) rdy_q <= !req;
    if (sel_p && !select_n) sh <= cpha ? {~reply[7], reply} : {reply, 1'b0};
    else if (!select_n && (cpha ? lead : trail)) sh <= sh << 1;
    if (!select_n && (cpha ? trail : lead)) got <= {got[6:0], mosi};
  end
endmodule

// ### verification/tb_spi_flow_ctrl.sv
// Bench for the flow-control block: slave model, bench as master.
// Assumes a 125 MHz clock and cfg changed only while idle.
`timescale 1ns/1ps
module tb_spi_flow_ctrl;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic tick_32k = 1'b0;
  spi_flow_pkg::cfg_t cfg = '0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  // Bench master pins and model control
  logic m_sclk = 1'b0;
  logic m_sel_n = 1'b1;
  logic m_mosi = 1'b0;
  logic req = 1'b0;
  logic [7:0] reply = 8'h00;
  logic tx_ready, rx_valid, sclk_o, sclk_oe, select_n_o, select_n_oe;
  logic mosi_o, mosi_oe, miso_o, miso_oe, busy, ready_n, s_miso;
  logic [7:0] rx_data;
  logic [7:0] got;
  int tcnt = 0;
  int miscompares = 0;
  int checked = 0;
  // Wire levels from every party's enable
  wire sclk_w = sclk_oe ? sclk_o : m_sclk;
  wire sel_w = select_n_oe ? select_n_o : m_sel_n;
  wire mosi_w = mosi_oe ? mosi_o : m_mosi;
  wire miso_w = miso_oe ? miso_o : s_miso;
  spi_flow_ctrl i_spi_flow_ctrl (.mclk(mclk), .rst(rst), .ce(ce),
    .cfg(cfg), .tick_32k(tick_32k), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .sclk_i(sclk_w),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .select_n_i(sel_w),
    .select_n_o(select_n_o), .select_n_oe(select_n_oe),
    .ready_n_i(ready_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe(miso_oe), .busy(busy));
  spi_slave_model i_spi_slave_model (.mclk(mclk), .cpol(cfg.cpol),
    .cpha(cfg.cpha), .select_n(sel_w), .sclk(sclk_w), .mosi(mosi_w),
    .reply(reply), .req(req), .miso(s_miso), .ready_n(ready_n),
    .got(got));
  initial forever #4 mclk = ~mclk;
  // Slow tick, one pulse per 32.768 kHz period
  always @(posedge mclk) begin
    tcnt <= (tcnt == 3814) ? 0 : tcnt + 1;
    tick_32k <= (tcnt == 3814);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // Static setup; idle sclk follows the polarity
  task automatic setup(input logic m, input spi_flow_pkg::rdy_mode_t r,
      input logic p, input logic h, input logic k, input logic [14:0] w);
    int i;
    // Configuration may only move while the block is idle
    for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
      cyc(1);
    end
    if (i >= 20000) begin
      chk(1'b0, "idle timeout");
      complete_run();
    end else begin
      cfg <= '{master: m, rdy_mode: r, cpol: p, cpha: h, div: 4'h3,
        wait_cnt: w, wait_32k: k};
      m_sclk <= p;
      cyc(2);
    end
  endtask
  // Two words back to back; valid held across both
  task automatic push2(input logic [7:0] a, input logic [7:0] b);
    tx_valid <= 1'b1;
    tx_data <= a;
    cyc(1);
    chk(tx_ready, "tx refused");
    tx_data <= b;
    cyc(1);
    chk(tx_ready, "tx refused");
    tx_valid <= 1'b0;
  endtask
  // Bounded wait for a word, then one pop
  task automatic pop(input logic [7:0] e, input string what);
    int i = 0;
    cyc(1);
    while (rx_valid !== 1'b1 && i < 10000) begin
      cyc(1);
      i++;
    end
    if (i >= 10000) begin
      chk(1'b0, "rx timeout");
      complete_run();
    end else begin
      rx_ready <= 1'b1;
      chk(rx_data === e, what);
      cyc(1);
      rx_ready <= 1'b0;
    end
  endtask
  // Two master frames: model reply back, sent word at the model
  task automatic frames(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] r);
    pop(r, "rx one");
    chk(got === a, "tx one");
    pop(r, "rx two");
    chk(got === b, "tx two");
  endtask
  // Edge start: one frame for each fall of ready
  task automatic t_edge();
    setup(1'b1, spi_flow_pkg::RDY_EDGE, 1'b0, 1'b0, 1'b0, 15'h0);
    reply <= 8'h69;
    push2(8'h81, 8'h7e);
    cyc(100);
    chk(busy === 1'b0, "start without fall");
    req <= 1'b1;
    pop(8'h69, "edge rx");
    chk(got === 8'h81, "edge tx");
    cyc(100);
    chk(busy === 1'b0, "level taken as edge");
    req <= 1'b0;
    cyc(4);
    req <= 1'b1;
    pop(8'h69, "edge rx");
    chk(got === 8'h7e, "edge tx");
    req <= 1'b0;
  endtask
  // Level start waits for ready low
  task automatic t_level();
    setup(1'b1, spi_flow_pkg::RDY_LEVEL, 1'b0, 1'b0, 1'b0, 15'h2);
    reply <= 8'h5a;
    push2(8'h96, 8'h3c);
    cyc(100);
    chk(busy === 1'b0, "start on ready high");
    req <= 1'b1;
    frames(8'h96, 8'h3c, 8'h5a);
    req <= 1'b0;
  endtask
  // Fixed rate with ready high, gap in slow ticks, idle-high clock
  task automatic t_ignore();
    setup(1'b1, spi_flow_pkg::RDY_IGNORE, 1'b1, 1'b0, 1'b1, 15'h1);
    reply <= 8'hc3;
    cyc(4000);
    push2(8'he1, 8'h1e);
    frames(8'he1, 8'h1e, 8'hc3);
  endtask
  // Bench as master; the word out is sampled before its edge
  task automatic sframe(input logic h, input logic [7:0] d,
      input logic [7:0] e);
    logic [7:0] q;
    int i;
    // Head word needs a few clocks to settle before select falls
    cyc(4);
    m_sel_n <= 1'b0;
    cyc(8);
    for (i = 7; i >= 0; i--) begin
      if (h) m_sclk <= ~cfg.cpol;
      m_mosi <= d[i];
      cyc(4);
      q[i] = miso_o;
      chk(miso_oe === 1'b1, "miso not driven");
      m_sclk <= h ? cfg.cpol : ~cfg.cpol;
      cyc(4);
      if (!h) m_sclk <= cfg.cpol;
      if (!h) cyc(4);
    end
    cyc(4);
    m_sel_n <= 1'b1;
    m_mosi <= ~m_mosi;
    chk(q === e, "slave word out");
    pop(d, "slave word in");
    chk(miso_oe === 1'b0, "miso held after frame");
  endtask
  // Both phases; second word proves the pop at select rise
  task automatic t_slave();
    setup(1'b0, spi_flow_pkg::RDY_IGNORE, 1'b0, 1'b0, 1'b0, 15'h0);
    push2(8'ha5, 8'h4b);
    sframe(1'b0, 8'h3c, 8'ha5);
    setup(1'b0, spi_flow_pkg::RDY_IGNORE, 1'b1, 1'b1, 1'b0, 15'h0);
    sframe(1'b1, 8'hd2, 8'h4b);
  endtask
  // Eight words fill the transmit store; the ninth is refused
  task automatic t_full();
    int i;
    tx_valid <= 1'b1;
    for (i = 0; i < 9; i++) begin
      cyc(1);
      chk(tx_ready === (i < 8), "fill level");
    end
    tx_valid <= 1'b0;
  endtask
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    t_edge();
    t_level();
    t_ignore();
    t_slave();
    t_full();
    complete_run();
  end
endmodule
bind spi_flow_ctrl spi_flow_ctrl_props i_spi_flow_ctrl_props (
  .mclk(mclk), .rst(rst), .cfg(cfg), .tick_32k(tick_32k),
  .ready_n_i(ready_n_i), .rx_ready(rx_ready), .select_n_i(select_n_i),
  .rx_valid(rx_valid), .sclk_o(sclk_o), .select_n_o(select_n_o),
  .select_n_oe(select_n_oe), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
  .busy(busy));
